/* File: tb/scss_monitor.sv */
// Checker for the system clock source select outputs
`timescale 1ns/1ps
module scss_monitor
    import scss_pkg::*;
#(
    parameter int PRESC_W = 10,
    parameter int OUTDIV_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic crystal_input,
    input wire logic direct_clock_input,
    input wire logic [1:0] clock_source_select,
    input wire logic vco_bypass_bit,
    input wire logic oscillator_source_internal,
    input wire logic [PRESC_W-1:0] output_prescaler_field,
    input wire logic [OUTDIV_W-1:0] loop_output_divider_field,
    input wire logic system_clock,
    input wire scss_pkg::scss_mode_type active_mode,
    input wire logic active_source_internal,
    input wire logic switch_busy,
    input wire logic [PRESC_W:0] output_prescale_factor,
    input wire logic [OUTDIV_W:0] loop_output_divide_factor
);
    logic [1:0] settle;
    logic quiet;
    logic pass_mode;
    // Quiet: three enabled cycles with no switch, so pipelines are full
    assign quiet = settle == 2'h3 && clk_en && !switch_busy;
    assign pass_mode = active_mode == MODE_OSC_PASS ||
        (active_mode == MODE_PRESCALE && output_prescale_factor == 11'h001);
    // Count of settled cycles, saturating
    always_ff @(posedge ref_clk) begin
        if (rst || switch_busy || !clk_en) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    reset_values_a: assert property (disable iff (1'b0) rst |=> !system_clock
        && !switch_busy && active_mode == MODE_OSC_PASS)
        else $error("reset values wrong");
    direct_follow_a: assert property (
        quiet && active_mode == MODE_DIRECT
        |-> system_clock == $past(direct_clock_input, 2))
        else $error("direct clock not followed");
    osc_equiv_a: assert property (
        quiet && pass_mode && !active_source_internal
        |-> system_clock == $past(crystal_input, 2))
        else $error("undivided crystal not followed");
    prescale_factor_a: assert property (
        quiet && active_mode == MODE_PRESCALE && $stable(output_prescaler_field)
        |-> output_prescale_factor == {1'b0, output_prescaler_field} + 1'b1)
        else $error("prescale factor wrong");
    loop_factor_a: assert property (
        quiet && active_mode == MODE_LOOP && $stable(loop_output_divider_field)
        |-> loop_output_divide_factor == {1'b0, loop_output_divider_field} + 1'b1)
        else $error("loop output factor wrong");
    mode_derived_a: assert property (
        quiet && clock_source_select == 2'h2
        && $stable({clock_source_select, vco_bypass_bit})
        |-> active_mode == (vco_bypass_bit ? MODE_PRESCALE : MODE_LOOP))
        else $error("derived mode wrong");
    source_sel_a: assert property (
        quiet && active_mode != MODE_DIRECT && $stable(oscillator_source_internal)
        |-> active_source_internal == oscillator_source_internal)
        else $error("oscillator source wrong");
    drain_rise_a: assert property (
        switch_busy && $past(switch_busy) |-> !$rose(system_clock))
        else $error("clock rose during switch");
    park_low_a: assert property (
        switch_busy && !system_clock |=> !system_clock)
        else $error("clock left park early");
    park_len_a: assert property (
        $rose(switch_busy) |-> switch_busy [*3])
        else $error("switch sequence too short");
endmodule // scss_monitor

bind scss_clock_select scss_monitor #(.PRESC_W(PRESC_W),
    .OUTDIV_W(OUTDIV_W)) u_mon (
    .ref_clk, .rst, .clk_en, .crystal_input, .direct_clock_input,
    .clock_source_select, .vco_bypass_bit, .oscillator_source_internal,
    .output_prescaler_field, .loop_output_divider_field, .system_clock,
    .active_mode, .active_source_internal, .switch_busy,
    .output_prescale_factor, .loop_output_divide_factor);

/* File: tb/scss_osc_model.sv */
// Crystal, on-chip source and direct clock generators for the bench
`timescale 1ns/1ps
module scss_osc_model #(
    parameter int XH = 1,
    parameter int XL = 1,
    parameter int IH = 20,
    parameter int IL = 20,
    parameter int DH = 2,
    parameter int DL = 5
) (
    input wire logic ref_clk,
    output logic crystal_input,
    output logic internal_clock_input,
    output logic direct_clock_input
);
    localparam int HI [3] = '{XH, IH, DH};
    localparam int LO [3] = '{XL, IL, DL};
    int cnt [3] = '{0, 0, 0};
    logic [2:0] lvl = 3'h0;
    assign crystal_input = lvl[0];
    assign internal_clock_input = lvl[1];
    assign direct_clock_input = lvl[2];
    // Off the sampling edge; oscillators run free, never parked
    always @(negedge ref_clk) begin
        for (int i = 0; i < 3; i++) begin
            cnt[i] = cnt[i] + 1;
            if (cnt[i] >= (lvl[i] ? HI[i] : LO[i])) begin
                lvl[i] = !lvl[i];
                cnt[i] = 0;
            end
        end
    end
endmodule // scss_osc_model

/* File: tb/tb_system_clock_source_select.sv */
// Self-checking bench for the system clock source select block
`timescale 1ns/1ps
module tb_system_clock_source_select;
    import scss_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic crystal_input, internal_clock_input, direct_clock_input;
    logic [1:0] clock_source_select = 2'h0;
    logic vco_bypass_bit = 1'b1;
    logic oscillator_source_internal = 1'b0;
    logic [9:0] output_prescaler_field = 10'h000;
    logic [3:0] loop_input_divider_field = 4'h0;
    logic [7:0] loop_multiplier_field = 8'h01;
    logic [9:0] loop_output_divider_field = 10'h000;
    logic system_clock, active_source_internal, loop_locked, switch_busy;
    scss_mode_type active_mode;
    logic [10:0] output_prescale_factor, loop_output_divide_factor;
    int miscompares = 0;
    int total_checks = 0;
    int per, hi, n, sum;
    int kt [3] = '{1, 3, 1024};

    initial forever #50 ref_clk = !ref_clk;

    scss_osc_model u_osc (.ref_clk, .crystal_input, .internal_clock_input,
        .direct_clock_input);
    scss_clock_select u_dut (.ref_clk, .rst, .clk_en, .crystal_input,
        .internal_clock_input, .direct_clock_input, .clock_source_select,
        .vco_bypass_bit, .oscillator_source_internal, .output_prescaler_field,
        .loop_input_divider_field, .loop_multiplier_field,
        .loop_output_divider_field, .system_clock, .active_mode,
        .active_source_internal, .loop_locked, .switch_busy,
        .output_prescale_factor, .loop_output_divide_factor);

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // New setting at a falling edge; sw says whether a switch must follow
    task automatic apply(input logic [1:0] sel, input logic byp,
        input logic src, input logic [9:0] presc, input logic sw);
        logic seen;
        int w;
        seen = 1'b0;
        w = 0;
        @(negedge ref_clk);
        clock_source_select = sel;
        vco_bypass_bit = byp;
        oscillator_source_internal = src;
        output_prescaler_field = presc;
        repeat (4) begin
            @(negedge ref_clk);
            seen = seen | (switch_busy === 1'b1);
        end
        check("switch", seen, sw);
        while (switch_busy !== 1'b0 && w < 5000) begin
            @(negedge ref_clk);
            w++;
        end
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic wait_level(input logic v, inout int c);
        while (system_clock !== v && c < 5000) begin
            @(negedge ref_clk);
            c++;
        end
    endtask

    // High time and period of one system clock cycle, in ref_clk cycles
    task automatic measure(output int p, output int h);
        int c;
        c = 0;
        wait_level(1'b0, c);
        wait_level(1'b1, c);
        c = 0;
        wait_level(1'b0, c);
        h = c;
        wait_level(1'b1, c);
        p = c;
    endtask

    task automatic finish_test;
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Longest case is the 1024 prescale; loop lock is bounded separately
    initial begin
        #(80000 * 100);
        miscompares++;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        check("reset mode", active_mode, MODE_OSC_PASS);
        check("reset prescale", output_prescale_factor, 1);
        apply(2'h3, 1'b1, 1'b0, 10'h000, 1'b1);
        check("direct mode", active_mode, MODE_DIRECT);
        measure(per, hi);
        check("direct period", per, 7);
        check("direct high", hi, 2);
        // Frozen cycles must not disturb the clock or the settings
        clk_en = 1'b0;
        sum = system_clock;
        repeat (10) begin
            @(negedge ref_clk);
            check("frozen clock", system_clock, sum);
        end
        clk_en = 1'b1;
        check("frozen mode", active_mode, MODE_DIRECT);
        foreach (kt[i]) begin
            apply(2'h2, 1'b1, 1'b0, 10'(kt[i] - 1), 1'b1);
            check("div factor", output_prescale_factor, kt[i]);
            measure(per, hi);
            check("div period", per, 2 * kt[i]);
            check("div hi", hi, kt[i] == 1 ? 1 : kt[i] / 2 * 2);
        end
        apply(2'h2, 1'b1, 1'b1, 10'h001, 1'b1);
        check("source", active_source_internal, 1'b1);
        measure(per, hi);
        check("internal period", per, 80);
        apply(2'h2, 1'b0, 1'b1, 10'h001, 1'b1);
        check("loop mode", active_mode, MODE_LOOP);
        check("outdiv factor", loop_output_divide_factor, 1);
        // A brief match comes long before the loop settles; demand the
        // lock to hold for sixteen compare windows in a row
        n = 0;
        hi = 0;
        while (hi < 640 && n < 40000) begin
            @(negedge ref_clk);
            n++;
            hi = (loop_locked === 1'b1) ? hi + 1 : 0;
        end
        check("locked", loop_locked, 1'b1);
        // Loop jitters, so eight periods of twenty cycles are averaged
        sum = 0;
        n = 0;
        repeat (8) begin
            measure(per, hi);
            if (n != 0) begin
                check("loop step", per - n <= 3 && n - per <= 3, 1'b1);
            end
            n = per;
            sum += per;
        end
        check("loop period", sum >= 144 && sum <= 176, 1'b1);
        apply(2'h2, 1'b0, 1'b1, 10'h005, 1'b0);
        check("prescale kept", output_prescale_factor, 2);
        finish_test;
    end
endmodule // tb_system_clock_source_select

/* File: verilog/scss_clock_select.sv */
// System clock source select: direct, prescaled or loop-derived clock
`timescale 1ns/1ps

// Notes on behaviour
// - Select 11: system clock follows direct input
// - Select 10, bypass one: oscillator over prescale factor
// - Prescaler source: crystal or on-chip source
// - Factor one passes oscillator with its duty
// - Prescale factors up to 1024 supported
// - Select 10, bypass zero: loop drives clock
// - Loop factor: N over P times output divider
// - Loop reference: crystal or on-chip source
// - Loop frequency changes gradually, never abruptly
// - Crystal bypass at factor one equals direct
module scss_clock_select #(
    parameter int PRESC_W = scss_pkg::PRESC_FIELD_W,
    parameter int P_W = scss_pkg::P_FIELD_W,
    parameter int N_W = scss_pkg::N_FIELD_W,
    parameter int OUTDIV_W = scss_pkg::OUTDIV_FIELD_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic crystal_input,
    input wire logic internal_clock_input,
    input wire logic direct_clock_input,
    input wire logic [1:0] clock_source_select,
    input wire logic vco_bypass_bit,
    input wire logic oscillator_source_internal,
    input wire logic [PRESC_W-1:0] output_prescaler_field,
    input wire logic [P_W-1:0] loop_input_divider_field,
    input wire logic [N_W-1:0] loop_multiplier_field,
    input wire logic [OUTDIV_W-1:0] loop_output_divider_field,
    output logic system_clock,
    output scss_pkg::scss_mode_type active_mode,
    output logic active_source_internal,
    output logic loop_locked,
    output logic switch_busy,
    output logic [PRESC_W:0] output_prescale_factor,
    output logic [OUTDIV_W:0] loop_output_divide_factor
);
    import scss_pkg::*;

    // Applied configuration, only changed while the output is parked
    scss_mode_type mode_q;
    logic osc_internal_q;
    logic [PRESC_W-1:0] presc_q;
    logic [P_W-1:0] p_q;
    logic [N_W-1:0] n_q;
    logic [OUTDIV_W-1:0] outdiv_q;

    scss_switch_type state;
    scss_switch_type next_state;
    logic [1:0] park_count;
    logic load_cfg;
    logic direct_q;
    logic osc_pass_q;

    scss_mode_type req_mode;
    logic mode_differs;
    logic osc_differs;
    logic presc_differs;
    logic loop_differs;
    logic cfg_change;
    logic oscillator_clock;
    logic prescale_clock;
    logic loop_clock;
    logic loop_lock_raw;
    logic src_level;
    logic park_done;
    logic next_system_clock;

    // Decode of the select field and the bypass bit
    assign req_mode = (clock_source_select == CSEL_DIRECT) ?
                      MODE_DIRECT :
                      (clock_source_select != CSEL_DERIVED) ?
                      MODE_OSC_PASS :
                      vco_bypass_bit ? MODE_PRESCALE :
                      MODE_LOOP;

    // Only settings that matter to the requested mode force a switch
    assign mode_differs = (req_mode != mode_q);
    assign osc_differs = (req_mode != MODE_DIRECT) &&
                         (oscillator_source_internal != osc_internal_q);
    assign presc_differs = (req_mode == MODE_PRESCALE) &&
                           (output_prescaler_field != presc_q);
    assign loop_differs = (req_mode == MODE_LOOP) &&
                          ((loop_input_divider_field != p_q) ||
                           (loop_multiplier_field != n_q) ||
                           (loop_output_divider_field != outdiv_q));
    assign cfg_change = mode_differs || osc_differs ||
                        presc_differs || loop_differs;

    // Oscillator clock: crystal or on-chip source
    assign oscillator_clock = osc_internal_q ?
                              internal_clock_input :
                              crystal_input;

    // Output prescaler, cleared whenever it is not the live source
    scss_divider #(
        .FIELD_W(PRESC_W)
    ) u_presc_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .clear(load_cfg || (mode_q != MODE_PRESCALE)),
        .src_level(oscillator_clock),
        .div_field(presc_q),
        .div_out(prescale_clock)
    );

    // Loop runs only in loop mode; a reload restarts it from rest
    scss_loop #(
        .P_W(P_W),
        .N_W(N_W),
        .OUTDIV_W(OUTDIV_W)
    ) u_loop (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .enable((mode_q == MODE_LOOP) && !load_cfg),
        .ref_level(oscillator_clock),
        .p_field(p_q),
        .n_field(n_q),
        .outdiv_field(outdiv_q),
        .loop_clock(loop_clock),
        .locked(loop_lock_raw)
    );

    // Direct and undivided paths get one stage to match divider latency
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            direct_q <= 1'b0;
            osc_pass_q <= 1'b0;
        end else if (clk_en) begin
            direct_q <= direct_clock_input;
            osc_pass_q <= oscillator_clock;
        end
    end

    // Source selection from the applied mode
    assign src_level = (mode_q == MODE_DIRECT) ? direct_q :
                       (mode_q == MODE_PRESCALE) ? prescale_clock :
                       (mode_q == MODE_LOOP) ? loop_clock :
                       osc_pass_q;

    // Park ends once the minimum has passed and the new source is low
    assign park_done = (park_count == '0) && !src_level;

    // Switch sequence: finish the high phase, hold low, start clean
    always_comb begin
        next_state = state;
        unique case (state)
            SW_RUN: begin
                if (cfg_change) begin
                    next_state = SW_DRAIN;
                end
            end
            SW_DRAIN: begin
                if (!system_clock) begin
                    next_state = SW_PARK;
                end
            end
            SW_PARK: begin
                if (park_done && !cfg_change) begin
                    next_state = SW_RUN;
                end
            end
        endcase
    end

    // Config is taken on entry to park and again if it moves meanwhile
    assign load_cfg = ((state == SW_DRAIN) && !system_clock) ||
                      ((state == SW_PARK) && cfg_change);

    // Drain may only end a high phase, park holds the output low
    assign next_system_clock = (state == SW_RUN) ? src_level :
                               (state == SW_DRAIN) ?
                               (src_level && system_clock) :
                               1'b0;

    // Sequencer and park timer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= SW_RUN;
            park_count <= '0;
        end else if (clk_en) begin
            state <= next_state;
            if (load_cfg) begin
                park_count <= PARK_CYCLES;
            end else if (park_count != '0) begin
                park_count <= park_count - 2'h1;
            end
        end
    end

    // Applied configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q <= MODE_OSC_PASS;
            osc_internal_q <= 1'b0;
            presc_q <= PRESC_RESET;
            p_q <= P_RESET;
            n_q <= N_RESET;
            outdiv_q <= OUTDIV_RESET;
        end else if (clk_en && load_cfg) begin
            mode_q <= req_mode;
            osc_internal_q <= oscillator_source_internal;
            presc_q <= output_prescaler_field;
            p_q <= loop_input_divider_field;
            n_q <= loop_multiplier_field;
            outdiv_q <= loop_output_divider_field;
        end
    end

    // Clock output and status, all from flip-flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            system_clock <= 1'b0;
            switch_busy <= 1'b0;
            loop_locked <= 1'b0;
        end else if (clk_en) begin
            system_clock <= next_system_clock;
            switch_busy <= (next_state != SW_RUN);
            loop_locked <= (mode_q == MODE_LOOP) && loop_lock_raw;
        end
    end

    // Reported settings follow the applied configuration
    assign active_mode = mode_q;
    assign active_source_internal = osc_internal_q;
    assign output_prescale_factor = {1'b0, presc_q} +
                                    {{PRESC_W{1'b0}}, 1'b1};
    assign loop_output_divide_factor = {1'b0, outdiv_q} +
                                       {{OUTDIV_W{1'b0}}, 1'b1};

endmodule // scss_clock_select

/* File: verilog/scss_divider.sv */
// Edge-counting clock divider by field plus one, with pass-through at one
`timescale 1ns/1ps
module scss_divider #(
    parameter int FIELD_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic src_level,
    input wire logic [FIELD_W-1:0] div_field,
    output logic div_out
);
    logic src_q;
    logic [FIELD_W-1:0] edge_count;
    logic [FIELD_W:0] half_factor;
    logic src_rise;
    logic [FIELD_W-1:0] next_edge_count;
    logic next_div_out;

    // Factor is field plus one; high for the first half of the count
    assign half_factor = ({1'b0, div_field} + {{FIELD_W{1'b0}}, 1'b1}) >> 1;
    assign src_rise = src_level & ~src_q;
    assign next_edge_count = !src_rise ? edge_count :
                             (edge_count == div_field) ? '0 :
                             edge_count + {{(FIELD_W-1){1'b0}}, 1'b1};
    // Factor one follows the source level, keeping its duty cycle
    assign next_div_out = (div_field == '0) ? src_level :
                          ({1'b0, next_edge_count} < half_factor);

    // Counter restarts on clear so a new factor begins on a whole period
    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && clear)) begin
            src_q <= 1'b0;
            edge_count <= '0;
            div_out <= 1'b0;
        end else if (clk_en) begin
            src_q <= src_level;
            edge_count <= next_edge_count;
            div_out <= next_div_out;
        end
    end

endmodule // scss_divider

/* File: verilog/scss_loop.sv */
// Digital frequency-locked loop: input divider, tuned oscillator, output divider
`timescale 1ns/1ps
module scss_loop #(
    parameter int P_W = 4,
    parameter int N_W = 8,
    parameter int OUTDIV_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic ref_level,
    input wire logic [P_W-1:0] p_field,
    input wire logic [N_W-1:0] n_field,
    input wire logic [OUTDIV_W-1:0] outdiv_field,
    output logic loop_clock,
    output logic locked
);
    import scss_pkg::*;

    logic ref_q;
    logic [P_W-1:0] p_count;
    logic [LOOP_ACC_W-1:0] phase_acc;
    logic [LOOP_ACC_W-1:0] tune_word;
    logic vco_q;
    logic [N_W:0] vco_edges;
    logic ref_rise;
    logic ref_tick;
    logic vco_level;
    logic vco_rise;
    logic [N_W:0] n_factor;
    logic [LOOP_ACC_W-1:0] tune_up;
    logic [LOOP_ACC_W-1:0] tune_down;
    logic [LOOP_ACC_W-1:0] next_tune_word;

    // Reference divided by P gives the compare tick
    assign ref_rise = ref_level & ~ref_q;
    assign ref_tick = ref_rise && (p_count == p_field);
    assign vco_level = phase_acc[LOOP_ACC_W-1];
    assign vco_rise = vco_level & ~vco_q;
    assign n_factor = {1'b0, n_field} + {{N_W{1'b0}}, 1'b1};

    // One small step per compare: frequency only slides, never jumps
    assign tune_up = (tune_word >= LOOP_INC_MAX - LOOP_INC_STEP) ?
                     LOOP_INC_MAX : tune_word + LOOP_INC_STEP;
    assign tune_down = (tune_word <= LOOP_INC_MIN + LOOP_INC_STEP) ?
                       LOOP_INC_MIN : tune_word - LOOP_INC_STEP;
    assign next_tune_word = !ref_tick ? tune_word :
                            (vco_edges < n_factor) ? tune_up :
                            (vco_edges > n_factor) ? tune_down :
                            tune_word;

    // Loop is held in its start state while not selected
    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && !enable)) begin
            ref_q <= 1'b0;
            p_count <= '0;
            phase_acc <= '0;
            tune_word <= LOOP_INC_RESET;
            vco_q <= 1'b0;
            vco_edges <= '0;
            locked <= 1'b0;
        end else if (clk_en) begin
            ref_q <= ref_level;
            if (ref_rise) begin
                p_count <= ref_tick ? '0 :
                           p_count + {{(P_W-1){1'b0}}, 1'b1};
            end
            phase_acc <= phase_acc + tune_word;
            tune_word <= next_tune_word;
            vco_q <= vco_level;
            if (ref_tick) begin
                vco_edges <= {{N_W{1'b0}}, vco_rise};
                locked <= (vco_edges == n_factor);
            end else if (vco_rise && !(&vco_edges)) begin
                vco_edges <= vco_edges + {{N_W{1'b0}}, 1'b1};
            end
        end
    end

    // Output divider on the oscillator, cleared while the loop is idle
    scss_divider #(
        .FIELD_W(OUTDIV_W)
    ) u_outdiv_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .clear(!enable),
        .src_level(vco_level),
        .div_field(outdiv_field),
        .div_out(loop_clock)
    );

endmodule // scss_loop

/* File: verilog/scss_pkg.sv */
// Shared constants and types for the system clock source select block
package scss_pkg;

    // Field widths of the divider and multiplier settings, and the loop accumulator width
    localparam int PRESC_FIELD_W = 10;
    localparam int P_FIELD_W = 4;
    localparam int N_FIELD_W = 8;
    localparam int OUTDIV_FIELD_W = 10;
    localparam int LOOP_ACC_W = 16;

    // Clock source select codes
    localparam logic [1:0] CSEL_DIRECT = 2'h3;
    localparam logic [1:0] CSEL_DERIVED = 2'h2;

    // Reset values of the applied configuration
    localparam logic [PRESC_FIELD_W-1:0] PRESC_RESET = 10'h000;
    localparam logic [P_FIELD_W-1:0] P_RESET = 4'h0;
    localparam logic [N_FIELD_W-1:0] N_RESET = 8'h00;
    localparam logic [OUTDIV_FIELD_W-1:0] OUTDIV_RESET = 10'h000;

    // Loop oscillator tuning word: start value, step and limits
    localparam logic [LOOP_ACC_W-1:0] LOOP_INC_RESET = 16'h0400;
    localparam logic [LOOP_ACC_W-1:0] LOOP_INC_STEP = 16'h0010;
    localparam logic [LOOP_ACC_W-1:0] LOOP_INC_MAX = 16'h8000;
    localparam logic [LOOP_ACC_W-1:0] LOOP_INC_MIN = 16'h0010;

    // Park timer load value; the output stays parked low for at least one cycle more
    localparam logic [1:0] PARK_CYCLES = 2'h2;

    // Clock generation mechanism in effect
    typedef enum logic [1:0] {
        MODE_OSC_PASS,
        MODE_PRESCALE,
        MODE_LOOP,
        MODE_DIRECT
    } scss_mode_type;

    // Glitch-free switch sequencer states
    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN,
        SW_PARK
    } scss_switch_type;

endpackage
